// ==== bench/decoder_model.sv ====
`timescale 1ns/10ps
// Decoder timing and sample stream seen by the capture block
module decoder_model (
  // Clock
  input wire sys_clk,
  // Timing and samples
  output reg horizontal_reset_pulse,
  output reg vertical_reset_pulse,
  output reg field_odd,
  output reg sample_valid,
  output reg [7:0] sample_data
);
  integer i;
  // Idle levels at start
  initial begin
    horizontal_reset_pulse = 1'b0;
    vertical_reset_pulse = 1'b0;
    field_odd = 1'b0;
    sample_valid = 1'b0;
    sample_data = 8'h00;
  end
  // Field start pulse carrying the field flag
  task field(input reg odd);
    begin
      @(posedge sys_clk);
      field_odd <= odd;
      vertical_reset_pulse <= 1'b1;
      repeat (3) @(posedge sys_clk);
      vertical_reset_pulse <= 1'b0;
    end
  endtask
  // Line pulse, then n samples numbered from zero
  task line(input integer n);
    begin
      @(posedge sys_clk);
      horizontal_reset_pulse <= 1'b1;
      repeat (4) @(posedge sys_clk);
      horizontal_reset_pulse <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        sample_data <= i[7:0];
      end
      @(posedge sys_clk);
      sample_valid <= 1'b0;
      sample_data <= ~sample_data; // Stale byte never repeats
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule

// ==== bench/vbi_capture_window_control_monitor.sv ====
`timescale 1ns/10ps
// Port checker for the capture window block
module vbi_capture_window_control_monitor (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Timing and samples
  input wire horizontal_reset_pulse,
  input wire vertical_reset_pulse,
  input wire sample_valid,
  // Register port
  input wire [3:0] reg_addr,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  // FIFO side
  input wire fifo_write,
  input wire [31:0] fifo_data,
  input wire fifo_frame_mode,
  input wire fifo_block_end
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  reg [8:0] fwords;
  reg vr_q;
  // Frame words since the last block end or field start
  always @(posedge sys_clk) begin
    vr_q <= vertical_reset_pulse;
    if (!nrst || (vertical_reset_pulse && !vr_q)) begin
      fwords <= 9'h000;
    end else if (fifo_write && fifo_frame_mode) begin
      fwords <= fifo_block_end ? 9'h000 : fwords + 9'h001;
    end
  end
  // No line-mode word for a few cycles
  sequence s_no_line_word;
    !(fifo_write && !fifo_frame_mode) [*3];
  endsequence
  AST_RDATA_IDLE: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  AST_HOLE_ZERO: assert property (
    reg_read && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
    else $error("hole read not zero");
  AST_WORD_SPACING: assert property (
    fifo_write |=> !fifo_write [*3]) else $error("word under 4 bytes");
  AST_WORD_LATENCY: assert property (
    fifo_write |-> $past(sample_valid, 2)) else $error("word without byte");
  AST_BLOCK_FRAME: assert property (
    fifo_block_end |-> fifo_write && fifo_frame_mode)
    else $error("block end outside frame");
  AST_BLOCK_SIZE: assert property (
    fifo_block_end |-> fwords == 9'h0FF) else $error("block size wrong");
  AST_WORD_HOLD: assert property (
    !fifo_write |-> $stable(fifo_data) && $stable(fifo_frame_mode))
    else $error("word changed without write");
  AST_HFALL_QUIET: assert property (
    $fell(horizontal_reset_pulse) |-> s_no_line_word)
    else $error("word before line start");
  AST_VRISE_QUIET: assert property (
    $rose(vertical_reset_pulse) |-> s_no_line_word)
    else $error("word on field start");
endmodule

bind vbi_capture_window_control vbi_capture_window_control_monitor i_mon (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .horizontal_reset_pulse(horizontal_reset_pulse),
  .vertical_reset_pulse(vertical_reset_pulse),
  .sample_valid(sample_valid),
  .reg_addr(reg_addr),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .fifo_write(fifo_write),
  .fifo_data(fifo_data),
  .fifo_frame_mode(fifo_frame_mode),
  .fifo_block_end(fifo_block_end)
);

// ==== bench/vbi_capture_window_control_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench for the capture window block
module vbi_capture_window_control_tb;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg std_625 = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg fifo_full = 1'b0;
  wire horizontal_reset_pulse, vertical_reset_pulse, field_odd;
  wire sample_valid, fifo_write, fifo_frame_mode, fifo_block_end;
  wire [7:0] sample_data;
  wire [31:0] reg_rdata, fifo_data;
  integer err_total = 0;
  integer checks = 0;
  integer cycles = 0;
  integer k;
  integer nb;
  reg [31:0] rv;
  logic [33:0] words [$];

  always #2 sys_clk = ~sys_clk;

  decoder_model i_decoder_model (
    .sys_clk(sys_clk),
    .horizontal_reset_pulse(horizontal_reset_pulse),
    .vertical_reset_pulse(vertical_reset_pulse),
    .field_odd(field_odd),
    .sample_valid(sample_valid),
    .sample_data(sample_data)
  );

  // Small block counts keep the frame scenarios short
  vbi_capture_window_control #(
    .BLOCK_LIMIT_525(10'd2),
    .BLOCK_LIMIT_625(10'd4),
    .BLOCK_LIMIT_525_EXT(10'd5),
    .BLOCK_LIMIT_625_EXT(10'd3)
  ) i_vbi_capture_window_control (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .horizontal_reset_pulse(horizontal_reset_pulse),
    .vertical_reset_pulse(vertical_reset_pulse),
    .field_odd(field_odd),
    .std_625(std_625),
    .sample_valid(sample_valid),
    .sample_data(sample_data),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .fifo_full(fifo_full),
    .fifo_write(fifo_write),
    .fifo_data(fifo_data),
    .fifo_frame_mode(fifo_frame_mode),
    .fifo_block_end(fifo_block_end)
  );

  // Collect words with block end and mode flags
  always @(posedge sys_clk) begin
    if (fifo_write === 1'b1) begin
      words.push_back({fifo_block_end, fifo_frame_mode, fifo_data});
    end
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      results;
    end
  end
  // Compare and report
  task chk(input string what, input [33:0] exp, input [33:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %s exp %h got %h", what, exp, got);
      end
    end
  endtask
  // Register write, one cycle
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
    end
  endtask
  // Register read, data taken the cycle after
  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // Reset values, readback and a hole
  task t_regs;
    begin
      rd(4'h8, rv);
      chk("vertical_line_delay", 34'h16, rv);
      wr(4'h4, 32'h10203);
      rd(4'h4, rv);
      chk("packet", 34'h10203, rv);
      rd(4'h2, rv);
      chk("hole", 34'h0, rv);
    end
  endtask
  // Line mode in odd blanking lines only
  task t_line;
    begin
      wr(4'h0, 32'h22);
      wr(4'h4, 32'h203);
      wr(4'h8, 32'h4);
      i_decoder_model.field(1'b0);
      i_decoder_model.line(24);
      chk("early", 34'h0, words.size());
      i_decoder_model.field(1'b1);
      for (k = 0; k < 4; k = k + 1) i_decoder_model.line(24);
      chk("count", 34'd9, words.size());
      chk("w0", 34'h007060504, words[0]);
      chk("w2", 34'h00F0E0D0C, words[2]);
      i_decoder_model.field(1'b0);
      i_decoder_model.line(24);
      chk("even", 34'd9, words.size());
      i_decoder_model.field(1'b1);
      fifo_full <= 1'b1;
      i_decoder_model.line(24);
      fifo_full <= 1'b0;
      chk("full", 34'd9, words.size());
      rd(4'hC, rv);
      chk("ovf", 34'h1, rv[31]);
      wr(4'hC, 32'h80000000);
      rd(4'hC, rv);
      chk("ovf clr", 34'h0, rv[31]);
    end
  endtask
  // Nine-bit count, then frame mode across a line
  task t_frame;
    begin
      words.delete();
      wr(4'h0, 32'h2A);
      wr(4'h4, 32'h10001);
      wr(4'h8, 32'h2);
      i_decoder_model.field(1'b1);
      i_decoder_model.line(1100);
      i_decoder_model.line(1102);
      i_decoder_model.line(8);
      chk("size", 34'd534, words.size());
      chk("last line", 34'h003020100, words[256]);
      chk("first frm", 34'h103020100, words[257]);
      chk("blk end", 34'h3FFFEFDFC, words[512]);
      chk("across", 34'h101004D4C, words[532]);
      rd(4'hC, rv);
      chk("fed", 34'h1, rv[25:16]);
      chk("frm run", 34'h1, rv[29]);
      i_decoder_model.field(1'b0);
      i_decoder_model.line(24);
      chk("even", 34'd534, words.size());
    end
  endtask
  // Extension on a 625-line field: early start, block count, then stop
  task t_blocks;
    begin
      words.delete();
      std_625 <= 1'b1;
      wr(4'h0, 32'h1A);
      wr(4'h8, 32'h2);
      i_decoder_model.field(1'b1);
      for (k = 0; k < 4; k = k + 1) i_decoder_model.line(1100);
      chk("ext first", 34'h103020100, words[0]);
      chk("ext words", 34'd768, words.size());
      nb = 0;
      for (k = 0; k < words.size(); k = k + 1) begin
        if (words[k][33]) nb = nb + 1;
      end
      chk("ext blocks", 34'd3, nb);
      rd(4'hC, rv);
      chk("blk fed", 34'h3, rv[25:16]);
      chk("frm stop", 34'h0, rv[29]);
      std_625 <= 1'b0;
    end
  endtask
  // Verdict
  task results;
    begin
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_line;
    t_frame;
    t_blocks;
    results;
  end
endmodule

// ==== common/vbi_consts.vh ====
// Overview of operation
// - Line mode starts each line after the programmed count past horizontal reset end.
// - Four blanking bytes pack into each FIFO word; one pixel is two samples.
// - Per-line word count joins the high bit and low byte into nine bits.
// - Line mode runs in even or odd field only when that field's enable is set.
// - Samples arrive at eight times subcarrier and enter the FIFO as bytes.
// - Each line stops once the programmed word count has been written.
// - Line mode covers lines from the first after vertical reset to active start.
// - Capture settings change only at frame boundaries.
// - Line mode and frame mode may both run within one field.
// - Frame mode captures in the active region including blanking and sync samples.
// - Frame mode starts at the first active line, cut into 256-word blocks.
// - Frame mode captures 434 blocks (525-line) or 650 blocks (625-line), then stops.
// - Extension starts frame mode ten lines early, but never before line 1; host sets vertical delay to 2.
// - With extension the block counts are 450 and 674.
// - Frame mode needs the field's capture enable and raw colour format.
// - Frame stream is continuous across lines, never realigned to sync.
// - Blanking words go to the FIFO like pixel data for the DMA engine.
// - Vertical delay gives the lines skipped after vertical reset before active.
`ifndef VBI_CONSTS_VH
`define VBI_CONSTS_VH

// Register offsets (byte addresses)
`define OFF_CONTROL 4'h0
`define OFF_PACKET 4'h4
`define OFF_VERTICAL_LINE_DELAY 4'h8
`define OFF_STATUS 4'hC

// Control register fields
`define CTL_CAPTURE_EVEN 0
`define CTL_CAPTURE_ODD 1
`define CTL_RAW_EVEN 2
`define CTL_RAW_ODD 3
`define CTL_EXTENSION 4
`define CTL_LINE_MODE 5
`define CTL_WIDTH 6

// Packet register fields
`define PKT_LOW_LSB 0
`define PKT_START_LSB 8
`define PKT_HIGH_BIT 16

// Status register fields
`define STS_OVERFLOW 31
`define STS_FIELD_ODD 30
`define STS_FRAME_BUSY 29
`define STS_LINE_BUSY 28
`define STS_BLOCKS_LSB 16

// Reset values
`define RST_CONTROL 6'h00
`define RST_DWORD_LOW 8'h00
`define RST_DWORD_HIGH 1'h0
`define RST_START 8'h00
`define RST_VERTICAL_LINE_DELAY 10'h016

// Frame mode counts
`define BLOCK_BYTES 10'h3FF
`define BLOCKS_525 10'd434
`define BLOCKS_625 10'd650
`define BLOCKS_525_EXT 10'd450
`define BLOCKS_625_EXT 10'd674
`define EXT_LINES 10'd10

`endif

// ==== hw/blanking_byte_packer.v ====
`timescale 1ns/10ps
// Collects four bytes, first byte in the low lane, into one word
module blanking_byte_packer (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Restart packing at lane zero
  input wire clear,
  // Byte side
  input wire byte_valid,
  input wire [7:0] byte_in,
  // Word side
  output reg word_valid,
  output reg [31:0] word_out
);

  reg [1:0] lane;
  reg [23:0] held;

  // Shift bytes into lanes and emit on the fourth
  always @(posedge sys_clk) begin
    if (!nrst) begin
      lane <= 2'h0;
      held <= 24'h000000;
      word_valid <= 1'b0;
      word_out <= 32'h00000000;
    end else begin
      word_valid <= 1'b0;
      if (clear) begin
        lane <= 2'h0;
      end else if (byte_valid) begin
        lane <= lane + 2'h1;
        case (lane)
          2'h0: held[7:0] <= byte_in;
          2'h1: held[15:8] <= byte_in;
          2'h2: held[23:16] <= byte_in;
          default: begin
            word_out <= {byte_in, held};
            word_valid <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// ==== hw/vbi_capture_window_control.v ====
`timescale 1ns/10ps
`include "vbi_consts.vh"
// Blanking-interval capture window: line mode and frame mode
module vbi_capture_window_control #(
  // Blocks per field, normal and extended, per line standard
  parameter [9:0] BLOCK_LIMIT_525 = `BLOCKS_525,
  parameter [9:0] BLOCK_LIMIT_625 = `BLOCKS_625,
  parameter [9:0] BLOCK_LIMIT_525_EXT = `BLOCKS_525_EXT,
  parameter [9:0] BLOCK_LIMIT_625_EXT = `BLOCKS_625_EXT
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Decoder timing, active high pulses
  input wire horizontal_reset_pulse,
  input wire vertical_reset_pulse,
  input wire field_odd,
  input wire std_625,
  // Decoder sample stream at eight times subcarrier
  input wire sample_valid,
  input wire [7:0] sample_data,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  // Capture FIFO side
  input wire fifo_full,
  output reg fifo_write,
  output reg [31:0] fifo_data,
  output reg fifo_frame_mode,
  output reg fifo_block_end
);

  // Staged settings written by software
  reg [`CTL_WIDTH-1:0] ctl_stage;
  reg [7:0] dword_low_stage;
  reg dword_high_stage;
  reg [7:0] start_stage;
  reg [9:0] vertical_line_delay_stage;

  // Settings in force for the current frame
  reg [`CTL_WIDTH-1:0] ctl_act;
  reg [8:0] blanking_dword_count;
  reg [7:0] blanking_line_start_count;
  reg [9:0] vertical_line_delay;

  // Timing state
  reg prev_h;
  reg prev_v;
  reg cur_odd;
  reg [9:0] line_cnt;

  // Line mode state
  reg line_busy;
  reg [8:0] sample_cnt;
  reg [10:0] line_bytes;

  // Frame mode state
  reg frame_busy;
  reg [9:0] block_bytes;
  reg [9:0] blocks_fed;
  reg [7:0] out_words;

  // Sticky error flag
  reg overflow;

  wire h_trail;
  wire v_lead;
  wire frame_boundary;
  wire [9:0] next_line;
  wire line_field_en;
  wire frame_field_en;
  wire line_go;
  wire frame_go;
  wire [9:0] frame_first_line;
  wire [9:0] block_limit;
  wire past_start;
  wire [10:0] line_byte_limit;
  wire line_feed;
  wire frame_feed;
  wire line_word_valid;
  wire [31:0] line_word;
  wire frame_word_valid;
  wire [31:0] frame_word;
  wire any_word;
  wire clear_overflow;

  // Edges of the decoder timing pulses
  assign h_trail = prev_h & ~horizontal_reset_pulse;
  assign v_lead = ~prev_v & vertical_reset_pulse;
  // A frame opens with the vertical reset that starts an odd field
  assign frame_boundary = v_lead & field_odd;
  assign next_line = line_cnt + 10'h001;

  // Field gating per mode
  assign line_field_en = ctl_act[`CTL_LINE_MODE] &
    (cur_odd ? ctl_act[`CTL_CAPTURE_ODD] :
     ctl_act[`CTL_CAPTURE_EVEN]);
  assign frame_field_en = cur_odd ?
    (ctl_act[`CTL_CAPTURE_ODD] & ctl_act[`CTL_RAW_ODD]) :
    (ctl_act[`CTL_CAPTURE_EVEN] & ctl_act[`CTL_RAW_EVEN]);

  // Line mode region: after vertical reset up to the active lines
  assign line_go = h_trail & line_field_en & (next_line >= 10'h001) &
    (next_line < vertical_line_delay);

  // Frame mode first line, moved up ten lines by the extension but never before line 1
  assign frame_first_line = !ctl_act[`CTL_EXTENSION] ?
    vertical_line_delay :
    ((vertical_line_delay > `EXT_LINES) ?
     (vertical_line_delay - `EXT_LINES) : 10'h001);
  assign frame_go = h_trail & frame_field_en & !frame_busy &
    (blocks_fed == 10'h000) & (next_line == frame_first_line);

  // Block count per field from line standard and extension
  assign block_limit = ctl_act[`CTL_EXTENSION] ?
    (std_625 ? BLOCK_LIMIT_625_EXT : BLOCK_LIMIT_525_EXT) :
    (std_625 ? BLOCK_LIMIT_625 : BLOCK_LIMIT_525);

  // Horizontal start counted in pixels, two samples each
  assign past_start = sample_cnt >= {blanking_line_start_count, 1'b0};
  assign line_byte_limit = {blanking_dword_count, 2'b00};
  assign line_feed = line_busy & sample_valid & past_start &
    (line_bytes < line_byte_limit);
  // Frame stream takes every sample, no realignment at line starts
  assign frame_feed = frame_busy & sample_valid;

  assign any_word = line_word_valid | frame_word_valid;
  assign clear_overflow = reg_write & (reg_addr == `OFF_STATUS) &
    reg_wdata[`STS_OVERFLOW];

  // Byte packer for line mode, restarted every line
  blanking_byte_packer u_line_packer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(h_trail),
    .byte_valid(line_feed),
    .byte_in(sample_data),
    .word_valid(line_word_valid),
    .word_out(line_word)
  );

  // Byte packer for frame mode, restarted only at field start
  blanking_byte_packer u_frame_packer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(v_lead),
    .byte_valid(frame_feed),
    .byte_in(sample_data),
    .word_valid(frame_word_valid),
    .word_out(frame_word)
  );

  // Staging registers written by software
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ctl_stage <= `RST_CONTROL;
      dword_low_stage <= `RST_DWORD_LOW;
      dword_high_stage <= `RST_DWORD_HIGH;
      start_stage <= `RST_START;
      vertical_line_delay_stage <= `RST_VERTICAL_LINE_DELAY;
    end else if (reg_write) begin
      case (reg_addr)
        `OFF_CONTROL: ctl_stage <= reg_wdata[`CTL_WIDTH-1:0];
        `OFF_PACKET: begin
          dword_low_stage <= reg_wdata[`PKT_LOW_LSB+7:`PKT_LOW_LSB];
          start_stage <= reg_wdata[`PKT_START_LSB+7:`PKT_START_LSB];
          dword_high_stage <= reg_wdata[`PKT_HIGH_BIT];
        end
        `OFF_VERTICAL_LINE_DELAY: vertical_line_delay_stage <= reg_wdata[9:0];
        default: ;
      endcase
    end
  end

  // All settings move into force together at the frame boundary
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ctl_act <= `RST_CONTROL;
      blanking_dword_count <= {`RST_DWORD_HIGH, `RST_DWORD_LOW};
      blanking_line_start_count <= `RST_START;
      vertical_line_delay <= `RST_VERTICAL_LINE_DELAY;
    end else if (frame_boundary) begin
      ctl_act <= ctl_stage;
      blanking_dword_count <= {dword_high_stage, dword_low_stage};
      blanking_line_start_count <= start_stage;
      vertical_line_delay <= vertical_line_delay_stage;
    end
  end

  // Line counter and field parity
  always @(posedge sys_clk) begin
    if (!nrst) begin
      prev_h <= 1'b0;
      prev_v <= 1'b0;
      cur_odd <= 1'b0;
      line_cnt <= 10'h000;
    end else begin
      prev_h <= horizontal_reset_pulse;
      prev_v <= vertical_reset_pulse;
      if (v_lead) begin
        cur_odd <= field_odd;
        line_cnt <= 10'h000;
      end else if (h_trail && line_cnt != 10'h3FF) begin
        line_cnt <= next_line;
      end
    end
  end

  // Line mode window: start offset, then a fixed number of words
  always @(posedge sys_clk) begin
    if (!nrst) begin
      line_busy <= 1'b0;
      sample_cnt <= 9'h000;
      line_bytes <= 11'h000;
    end else if (v_lead) begin
      line_busy <= 1'b0;
    end else if (h_trail) begin
      line_busy <= line_go;
      sample_cnt <= 9'h000;
      line_bytes <= 11'h000;
    end else if (line_busy && sample_valid) begin
      if (!past_start) begin
        sample_cnt <= sample_cnt + 9'h001;
      end else if (line_feed) begin
        line_bytes <= line_bytes + 11'h001;
        if (line_bytes + 11'h001 == line_byte_limit) begin
          line_busy <= 1'b0;
        end
      end else begin
        line_busy <= 1'b0;
      end
    end
  end

  // Frame mode: fixed number of 1024-byte blocks per field
  always @(posedge sys_clk) begin
    if (!nrst) begin
      frame_busy <= 1'b0;
      block_bytes <= 10'h000;
      blocks_fed <= 10'h000;
    end else if (v_lead) begin
      frame_busy <= 1'b0;
      block_bytes <= 10'h000;
      blocks_fed <= 10'h000;
    end else if (frame_go) begin
      frame_busy <= (block_limit != 10'h000);
    end else if (frame_feed) begin
      block_bytes <= block_bytes + 10'h001;
      if (block_bytes == `BLOCK_BYTES) begin
        blocks_fed <= blocks_fed + 10'h001;
        if (blocks_fed + 10'h001 == block_limit) begin
          frame_busy <= 1'b0;
        end
      end
    end
  end

  // Words go to the FIFO as ordinary pixel data; line mode wins a tie
  always @(posedge sys_clk) begin
    if (!nrst) begin
      fifo_write <= 1'b0;
      fifo_data <= 32'h00000000;
      fifo_frame_mode <= 1'b0;
      fifo_block_end <= 1'b0;
      out_words <= 8'h00;
    end else begin
      fifo_write <= any_word & !fifo_full;
      fifo_block_end <= 1'b0;
      if (v_lead) begin
        out_words <= 8'h00;
      end
      // A dropped word leaves the last written one on show
      if (line_word_valid) begin
        if (!fifo_full) begin
          fifo_data <= line_word;
          fifo_frame_mode <= 1'b0;
        end
      end else if (frame_word_valid) begin
        if (!fifo_full) begin
          fifo_data <= frame_word;
          fifo_frame_mode <= 1'b1;
        end
        if (!v_lead) begin
          out_words <= out_words + 8'h01;
        end
        fifo_block_end <= (out_words == 8'hFF) & !fifo_full;
      end
    end
  end

  // Sticky drop flag: a new drop wins over a clear in the same cycle
  always @(posedge sys_clk) begin
    if (!nrst) begin
      overflow <= 1'b0;
    end else if (any_word && fifo_full) begin
      overflow <= 1'b1;
    end else if (clear_overflow) begin
      overflow <= 1'b0;
    end
  end

  // Read data, valid the cycle after the read strobe
  always @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        `OFF_CONTROL: reg_rdata <= {26'h0000000, ctl_stage};
        `OFF_PACKET: reg_rdata <= {15'h0000, dword_high_stage,
          start_stage, dword_low_stage};
        `OFF_VERTICAL_LINE_DELAY: reg_rdata <= {22'h000000, vertical_line_delay_stage};
        `OFF_STATUS: reg_rdata <= {overflow, cur_odd, frame_busy,
          line_busy, 2'h0, blocks_fed, 6'h00, line_cnt};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule
